// ===== fagc_pkg.sv
package fagc_pkg;

	// ----------------------------------------
	// command byte addresses
	// ----------------------------------------
	localparam logic [7:0] ADDR_FAULT_EN = 8'h02;
	localparam logic [7:0] ADDR_MEAS_EN = 8'h03;
	localparam logic [7:0] ADDR_FAULT_LOG = 8'h04;
	localparam logic [7:0] ADDR_MEAS_LOG = 8'h05;
	localparam logic [7:0] ADDR_BAD_WAIT = 8'h06;
	localparam logic [7:0] ADDR_PIN_CFG = 8'h07;
	localparam logic [7:0] ADDR_ALERT_CTRL = 8'h1c;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [15:0] RST_ALERT_EN = 16'h0000;
	localparam logic [7:0] RST_FAULT_LOG = 8'h00;
	localparam logic [7:0] RST_MEAS_LOG = 8'h00;
	localparam logic [7:0] RST_BAD_WAIT = 8'hff;
	localparam logic [7:0] RST_PIN_CFG = 8'h00;
	localparam logic [7:0] RST_ALERT_CTRL = 8'h00;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int FLT_XSTR_BAD = 6;
	localparam int FLT_ON_CHANGE = 4;
	localparam int CFG_THIRD_PD = 7;
	localparam int CFG_SECOND_PD = 6;
	localparam int CFG_FN_LSB = 4;
	localparam int CFG_OUT_VALUE = 3;
	localparam int CFG_CONV_EN = 2;
	localparam int CFG_STRESS = 1;
	localparam int CFG_OVF_EN = 0;
	localparam int ACTL_CLEAR = 7;
	localparam int ACTL_FORCE = 6;
	localparam int PEND_CONV = 16;
	localparam int PEND_OVF = 17;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_TIME_NS = 1000000;
	localparam int MS_CYCLES = MS_TIME_NS / CLK_PERIOD_NS;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {
		FN_POWER_GOOD = 2'h0,
		FN_POWER_BAD = 2'h2,
		FN_OUTPUT = 2'h1,
		FN_INPUT = 2'h3
	} fagc_pin_fn_t;

	typedef struct packed {
		logic eeprom_done;
		logic xstr_short;
		logic power_bad;
		logic overcurrent;
		logic undervoltage;
		logic overvoltage;
	} fagc_fault_ev_t;

	typedef struct packed {
		logic valid;
		logic [1:0] chan;
		logic [7:0] value;
		logic [7:0] min_thr;
		logic [7:0] max_thr;
	} fagc_meas_t;

endpackage

// ===== fagc_top.sv
`timescale 1ns/100ps
module fagc_top #(
	parameter int MS_CYCLES = fagc_pkg::MS_CYCLES
) (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RST_N,
	// command register port
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	// protection events
	input wire fagc_pkg::fagc_fault_ev_t FAULT_EV,
	input wire logic XSTR_BAD_COND,
	input wire logic ON_PIN,
	input wire logic ON_FAULT_MASK,
	input wire logic POWER_GOOD,
	input wire logic XSTR_STRESS,
	input wire logic METER_OVF,
	// measurements
	input wire fagc_pkg::fagc_meas_t MEAS,
	// alert and pins
	output logic ALERT_N,
	input wire logic [2:0] GPIO_IN,
	output logic [2:0] GPIO_OUT,
	output logic [2:0] GPIO_OE_N,
	output logic [2:0] GPIO_LEVEL
);

	// ----------------------------------------
	// elaboration check
	// ----------------------------------------
	if (MS_CYCLES < 1) begin : g_bad_ms
		$error("MS_CYCLES must be at least one");
	end

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_TIMING = 3'b010,
		ST_FAULTED = 3'b100
	} fagc_bad_st_t;

	logic [15:0] alert_en_r;
	logic [7:0] fault_log_r;
	logic [7:0] meas_log_r;
	logic [7:0] bad_wait_r;
	logic [7:0] pin_cfg_r;
	logic force_r;
	logic [17:0] pend_r;
	logic on_prev_r;
	fagc_bad_st_t bad_st_r;
	logic [31:0] tick_cnt_r;
	logic [7:0] ms_cnt_r;
	logic ms_tick;
	logic bad_ev;
	logic on_change;
	logic on_clear;
	logic [7:0] fault_set;
	logic [7:0] meas_up_set;
	logic [7:0] meas_lo_set;
	logic [7:0] meas_log_set;
	logic [7:0] meas_alert_set;
	logic [17:0] pend_set;
	logic clear_pend;
	logic [1:0] pin_fn;
	logic first_drive;
	logic second_drive;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic wr_hit(input logic [7:0] a);
		wr_hit = REG_WR && (REG_ADDR == a);
	endfunction

	function automatic logic [7:0] chan_bit(input logic [1:0] ch, input logic upper);
		logic [2:0] idx;
		idx = {ch, upper};
		chan_bit = 8'h01 << idx;
	endfunction

	// ----------------------------------------
	// event decode
	// ----------------------------------------
	assign on_change = ON_PIN != on_prev_r;
	assign on_clear = on_change && !ON_FAULT_MASK;
	assign fault_set = {FAULT_EV.eeprom_done, bad_ev, FAULT_EV.xstr_short, on_change,
		FAULT_EV.power_bad, FAULT_EV.overcurrent, FAULT_EV.undervoltage,
		FAULT_EV.overvoltage};
	assign meas_up_set = (MEAS.valid && MEAS.value > MEAS.max_thr) ?
		chan_bit(MEAS.chan, 1'b1) : 8'h00;
	assign meas_lo_set = (MEAS.valid && MEAS.value < MEAS.min_thr) ?
		chan_bit(MEAS.chan, 1'b0) : 8'h00;
	assign meas_log_set = meas_up_set | meas_lo_set;
	assign meas_alert_set = ((MEAS.valid && MEAS.value >= MEAS.max_thr) ?
		chan_bit(MEAS.chan, 1'b1) : 8'h00)
		| ((MEAS.valid && MEAS.value <= MEAS.min_thr) ?
		chan_bit(MEAS.chan, 1'b0) : 8'h00);
	assign pend_set = {METER_OVF && pin_cfg_r[fagc_pkg::CFG_OVF_EN],
		MEAS.valid && pin_cfg_r[fagc_pkg::CFG_CONV_EN],
		meas_alert_set & alert_en_r[15:8],
		fault_set & alert_en_r[7:0]};
	assign clear_pend = wr_hit(fagc_pkg::ADDR_ALERT_CTRL) && REG_WDATA[fagc_pkg::ACTL_CLEAR];

	// ----------------------------------------
	// writable configuration
	// ----------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			alert_en_r <= fagc_pkg::RST_ALERT_EN;
			bad_wait_r <= fagc_pkg::RST_BAD_WAIT;
			pin_cfg_r <= fagc_pkg::RST_PIN_CFG;
			force_r <= fagc_pkg::RST_ALERT_CTRL[fagc_pkg::ACTL_FORCE];
		end else begin
			if (wr_hit(fagc_pkg::ADDR_FAULT_EN))
				alert_en_r[7:0] <= REG_WDATA;
			if (wr_hit(fagc_pkg::ADDR_MEAS_EN))
				alert_en_r[15:8] <= REG_WDATA;
			if (wr_hit(fagc_pkg::ADDR_BAD_WAIT))
				bad_wait_r <= REG_WDATA;
			if (wr_hit(fagc_pkg::ADDR_PIN_CFG))
				pin_cfg_r <= REG_WDATA;
			if (wr_hit(fagc_pkg::ADDR_ALERT_CTRL))
				force_r <= REG_WDATA[fagc_pkg::ACTL_FORCE];
		end
	end

	// ----------------------------------------
	// sticky logs, set wins over clear
	// ----------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			fault_log_r <= fagc_pkg::RST_FAULT_LOG;
			meas_log_r <= fagc_pkg::RST_MEAS_LOG;
			on_prev_r <= ON_PIN;
		end else begin
			on_prev_r <= ON_PIN;
			if (wr_hit(fagc_pkg::ADDR_FAULT_LOG))
				fault_log_r <= REG_WDATA | fault_set;
			else if (on_clear)
				fault_log_r <= fault_set;
			else
				fault_log_r <= fault_log_r | fault_set;
			if (wr_hit(fagc_pkg::ADDR_MEAS_LOG))
				meas_log_r <= REG_WDATA | meas_log_set;
			else
				meas_log_r <= meas_log_r | meas_log_set;
		end
	end

	// ----------------------------------------
	// pending alerts and alert output
	// ----------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			pend_r <= '0;
			ALERT_N <= 1'b1;
		end else begin
			pend_r <= (clear_pend ? 18'h00000 : pend_r) | pend_set;
			ALERT_N <= !((|pend_r) || force_r);
		end
	end

	// ----------------------------------------
	// transistor-bad timer
	// ----------------------------------------
	assign ms_tick = tick_cnt_r == 32'(MS_CYCLES - 1);
	assign bad_ev = bad_st_r == ST_TIMING && XSTR_BAD_COND && bad_wait_r != 8'h00
		&& ms_tick && ({1'b0, ms_cnt_r} + 9'h001 >= {1'b0, bad_wait_r});

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			bad_st_r <= ST_IDLE;
			tick_cnt_r <= '0;
			ms_cnt_r <= 8'h00;
		end else begin
			case (bad_st_r)
				ST_IDLE: begin
					tick_cnt_r <= '0;
					ms_cnt_r <= 8'h00;
					if (XSTR_BAD_COND && bad_wait_r != 8'h00)
						bad_st_r <= ST_TIMING;
				end
				ST_TIMING: begin
					if (!XSTR_BAD_COND || bad_wait_r == 8'h00) begin
						bad_st_r <= ST_IDLE;
					end else if (bad_ev) begin
						bad_st_r <= ST_FAULTED;
					end else if (ms_tick) begin
						tick_cnt_r <= '0;
						ms_cnt_r <= ms_cnt_r + 8'h01;
					end else begin
						tick_cnt_r <= tick_cnt_r + 32'h00000001;
					end
				end
				ST_FAULTED: begin
					if (!XSTR_BAD_COND)
						bad_st_r <= ST_IDLE;
				end
				default: bad_st_r <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// general purpose pins
	// ----------------------------------------
	assign pin_fn = pin_cfg_r[fagc_pkg::CFG_FN_LSB+1:fagc_pkg::CFG_FN_LSB];

	always_comb begin
		case (fagc_pkg::fagc_pin_fn_t'(pin_fn))
			fagc_pkg::FN_POWER_GOOD: first_drive = !POWER_GOOD;
			fagc_pkg::FN_POWER_BAD: first_drive = POWER_GOOD;
			fagc_pkg::FN_OUTPUT: first_drive = !pin_cfg_r[fagc_pkg::CFG_OUT_VALUE];
			fagc_pkg::FN_INPUT: first_drive = 1'b0;
			default: first_drive = 1'b0;
		endcase
	end

	assign second_drive = pin_cfg_r[fagc_pkg::CFG_SECOND_PD]
		|| (pin_cfg_r[fagc_pkg::CFG_STRESS] && XSTR_STRESS);

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			GPIO_OUT <= 3'h0;
			GPIO_OE_N <= 3'h7;
			GPIO_LEVEL <= 3'h0;
		end else begin
			GPIO_OUT <= 3'h0;
			GPIO_OE_N[0] <= !first_drive;
			GPIO_OE_N[1] <= !second_drive;
			GPIO_OE_N[2] <= !pin_cfg_r[fagc_pkg::CFG_THIRD_PD];
			GPIO_LEVEL <= GPIO_IN;
		end
	end

	// ----------------------------------------
	// register read
	// ----------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			REG_RDATA <= 8'h00;
		end else if (REG_RD) begin
			case (REG_ADDR)
				fagc_pkg::ADDR_FAULT_EN: REG_RDATA <= alert_en_r[7:0];
				fagc_pkg::ADDR_MEAS_EN: REG_RDATA <= alert_en_r[15:8];
				fagc_pkg::ADDR_FAULT_LOG: REG_RDATA <= fault_log_r;
				fagc_pkg::ADDR_MEAS_LOG: REG_RDATA <= meas_log_r;
				fagc_pkg::ADDR_BAD_WAIT: REG_RDATA <= bad_wait_r;
				fagc_pkg::ADDR_PIN_CFG: REG_RDATA <= pin_cfg_r;
				fagc_pkg::ADDR_ALERT_CTRL: REG_RDATA <= {1'b0, force_r, 6'h00};
				default: REG_RDATA <= 8'h00;
			endcase
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);

	property p_fault_en;
		FAULT_EV.overvoltage && alert_en_r[0] && !clear_pend |=> pend_r[0];
	endproperty
	a_fault_en: assert property (p_fault_en) else $error("enabled fault not pending");

	property p_meas_up_alert;
		MEAS.valid && MEAS.chan == 2'h3 && MEAS.value == MEAS.max_thr && alert_en_r[15]
			&& !clear_pend |=> pend_r[15];
	endproperty
	a_meas_up_alert: assert property (p_meas_up_alert) else $error("equal max no alert");

	property p_meas_lo_log;
		MEAS.valid && MEAS.chan == 2'h0 && MEAS.value < MEAS.min_thr |=> meas_log_r[0];
	endproperty
	a_meas_lo_log: assert property (p_meas_lo_log) else $error("low alarm not logged");

	property p_meas_eq_nolog;
		MEAS.valid && MEAS.value == MEAS.max_thr && MEAS.value == MEAS.min_thr
			&& !wr_hit(fagc_pkg::ADDR_MEAS_LOG) |=> meas_log_r == $past(meas_log_r);
	endproperty
	a_meas_eq_nolog: assert property (p_meas_eq_nolog) else $error("equal value logged");

	property p_log_sticky;
		!wr_hit(fagc_pkg::ADDR_FAULT_LOG) && !on_clear
			|=> (fault_log_r & $past(fault_log_r)) == $past(fault_log_r);
	endproperty
	a_log_sticky: assert property (p_log_sticky) else $error("fault log bit lost");

	property p_mask_keeps;
		on_change && ON_FAULT_MASK && !wr_hit(fagc_pkg::ADDR_FAULT_LOG)
			|=> fault_log_r[fagc_pkg::FLT_ON_CHANGE] && (fault_log_r & $past(fault_log_r))
			== $past(fault_log_r);
	endproperty
	a_mask_keeps: assert property (p_mask_keeps) else $error("masked pin cleared log");

	property p_alert_out;
		1'b1 |=> ALERT_N == !((|$past(pend_r)) || $past(force_r));
	endproperty
	a_alert_out: assert property (p_alert_out) else $error("alert output mismatch");

	property p_clear;
		clear_pend && pend_set == 18'h00000 |=> pend_r == 18'h00000 ##1 ALERT_N || force_r;
	endproperty
	a_clear: assert property (p_clear) else $error("pending not cleared");

	property p_wait_zero;
		bad_wait_r == 8'h00 |-> !bad_ev ##1 bad_st_r != ST_TIMING;
	endproperty
	a_wait_zero: assert property (p_wait_zero) else $error("bad fault while disabled");

	property p_third_pin;
		wr_hit(fagc_pkg::ADDR_PIN_CFG) ##1 !wr_hit(fagc_pkg::ADDR_PIN_CFG)
			|=> GPIO_OE_N[2] == !$past(REG_WDATA[fagc_pkg::CFG_THIRD_PD], 2);
	endproperty
	a_third_pin: assert property (p_third_pin) else $error("third pin wrong");

	property p_conv_alert;
		MEAS.valid && pin_cfg_r[fagc_pkg::CFG_CONV_EN] && !clear_pend
			|=> pend_r[fagc_pkg::PEND_CONV] ##1 !ALERT_N;
	endproperty
	a_conv_alert: assert property (p_conv_alert) else $error("conversion alert missing");

	c_bad_fault: cover property (bad_ev ##1 fault_log_r[fagc_pkg::FLT_XSTR_BAD]);
	c_alert_clear: cover property (!ALERT_N ##1 clear_pend ##2 ALERT_N);
	c_stress_pin: cover property (XSTR_STRESS && pin_cfg_r[fagc_pkg::CFG_STRESS] ##1 !GPIO_OE_N[1]);

endmodule

// ===== fagc_host.sv
`timescale 1ns/100ps
// ----------------------------------------
// register port host model
// ----------------------------------------
module fagc_host (
	// clock
	input wire logic clk,
	// command register port
	output logic [7:0] addr,
	output logic [7:0] wdata,
	output logic wr,
	output logic rd
);
	initial begin
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
	end

	// one byte per strobe, held to the taking edge, then one idle cycle
	task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(posedge clk);
		#1;
		wr = 1'b0;
		wdata = ~d;
		addr = ~a;
		@(posedge clk);
		#1;
	endtask

	task automatic rd_byte(input logic [7:0] a);
		addr = a;
		rd = 1'b1;
		@(posedge clk);
		#1;
		rd = 1'b0;
		addr = ~a;
		@(posedge clk);
		#1;
	endtask
endmodule

// ===== test_fagc_top.sv
`timescale 1ns/100ps
module test_fagc_top;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	localparam int MS = 4;
	logic REF_CLK = 1'b0;
	logic RST_N = 1'b0;
	logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA;
	logic REG_WR, REG_RD, ALERT_N;
	fagc_pkg::fagc_fault_ev_t fev = '0;
	fagc_pkg::fagc_meas_t meas_in = '0;
	logic bad = 1'b0, on_pin = 1'b0, mask = 1'b1, pg = 1'b1, stress = 1'b0, ovf = 1'b0;
	logic [2:0] ext = 3'h7, pin_in, pin_out, pin_oe_n, pin_lvl;
	logic [7:0] expq[$];
	logic rd_d;
	int fails = 0, n_compared = 0, cnt = 0;

	assign pin_in = (pin_oe_n & ext) | (~pin_oe_n & pin_out);

	fagc_host host (.clk(REF_CLK), .addr(REG_ADDR), .wdata(REG_WDATA), .wr(REG_WR), .rd(REG_RD));

	fagc_top #(.MS_CYCLES(MS)) dut (
		.REF_CLK(REF_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
		.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .FAULT_EV(fev),
		.XSTR_BAD_COND(bad), .ON_PIN(on_pin), .ON_FAULT_MASK(mask), .POWER_GOOD(pg),
		.XSTR_STRESS(stress), .METER_OVF(ovf), .MEAS(meas_in), .ALERT_N(ALERT_N),
		.GPIO_IN(pin_in), .GPIO_OUT(pin_out), .GPIO_OE_N(pin_oe_n), .GPIO_LEVEL(pin_lvl)
	);

	initial begin
		forever #5 REF_CLK = ~REF_CLK;
	end

	// ----------------------------------------
	// compare and report
	// ----------------------------------------
	task automatic chk_rd(input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("wrong value read data expected %h seen %h", e, g);
		end
	endtask

	task automatic chk_pin(input string n, input logic [2:0] e, input logic [2:0] g);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic stop_test;
		$display("mismatches %0d compared %0d", fails, n_compared);
		if (fails == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	always @(posedge REF_CLK) begin
		rd_d <= REG_RD;
		cnt <= cnt + 1;
		if (cnt == 20000) begin
			fails++;
			stop_test();
		end
	end

	always @(negedge REF_CLK) begin
		if (rd_d === 1'b1)
			chk_rd(expq.pop_front(), REG_RDATA);
	end

	// ----------------------------------------
	// stimulus helpers
	// ----------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge REF_CLK);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host.wr_byte(a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		expq.push_back(e);
		host.rd_byte(a);
	endtask

	task automatic alert_is(input logic e);
		cyc(3);
		chk_pin("alert", {2'h0, e}, {2'h0, ALERT_N});
	endtask

	task automatic clr;
		wr(fagc_pkg::ADDR_ALERT_CTRL, 8'h80);
		cyc(2);
		chk_pin("alert", 3'h1, {2'h0, ALERT_N});
	endtask

	task automatic meas(input logic [1:0] c, input logic [7:0] v, input logic [7:0] r);
		meas_in = '{1'b1, c, v, r, r};
		cyc(1);
		meas_in.valid = 1'b0;
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	logic [7:0] ra[8] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h1c, 8'h50};
	logic [7:0] rv[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
	int lb[6] = '{0, 1, 2, 3, 5, 7};
	logic [7:0] gc[9] = '{8'h80, 8'h40, 8'h02, 8'h00, 8'h20, 8'h20, 8'h10, 8'h18, 8'h30};
	logic [1:0] gp[9] = '{2'h2, 2'h2, 2'h3, 2'h0, 2'h2, 2'h0, 2'h2, 2'h2, 2'h0};
	logic [2:0] ge[9] = '{3'h3, 3'h5, 3'h5, 3'h6, 3'h6, 3'h7, 3'h6, 3'h7, 3'h7};
	logic [7:0] r;
	initial begin
		void'($urandom(32'hec3f));
		cyc(2);
		RST_N = 1'b1;
		cyc(1);
		for (int i = 0; i < 8; i++) rd(ra[i], rv[i]);
		for (int i = 0; i < 6; i++) begin
			fev = fagc_pkg::fagc_fault_ev_t'(6'h1 << i);
			cyc(1);
			fev = '0;
			rd(fagc_pkg::ADDR_FAULT_LOG, 8'h1 << lb[i]);
			alert_is(1'b1);
			wr(fagc_pkg::ADDR_FAULT_LOG, 8'h00);
			rd(fagc_pkg::ADDR_FAULT_LOG, 8'h00);
			wr(fagc_pkg::ADDR_FAULT_EN, 8'h1 << lb[i]);
			fev = fagc_pkg::fagc_fault_ev_t'(6'h1 << i);
			cyc(1);
			fev = '0;
			alert_is(1'b0);
			wr(fagc_pkg::ADDR_FAULT_LOG, 8'h00);
			alert_is(1'b0);
			clr();
		end
		for (int c = 0; c < 4; c++) begin
			r = 8'($urandom_range(1, 254));
			wr(fagc_pkg::ADDR_MEAS_EN, 8'h1 << (2 * c + 1));
			meas(c[1:0], r, r);
			alert_is(1'b0);
			rd(fagc_pkg::ADDR_MEAS_LOG, 8'h00);
			clr();
			meas(c[1:0], r + 8'h1, r);
			rd(fagc_pkg::ADDR_MEAS_LOG, 8'h1 << (2 * c + 1));
			wr(fagc_pkg::ADDR_MEAS_EN, 8'h1 << (2 * c));
			clr();
			meas(c[1:0], r, r);
			alert_is(1'b0);
			clr();
			wr(fagc_pkg::ADDR_MEAS_LOG, 8'h00);
			meas(c[1:0], r - 8'h1, r);
			rd(fagc_pkg::ADDR_MEAS_LOG, 8'h1 << (2 * c));
			clr();
			wr(fagc_pkg::ADDR_MEAS_LOG, 8'h00);
		end
		wr(fagc_pkg::ADDR_MEAS_EN, 8'h00);
		wr(fagc_pkg::ADDR_PIN_CFG, 8'h05);
		meas(2'h1, 8'h80, 8'h80);
		alert_is(1'b0);
		clr();
		ovf = 1'b1;
		cyc(1);
		ovf = 1'b0;
		alert_is(1'b0);
		clr();
		wr(fagc_pkg::ADDR_PIN_CFG, 8'h00);
		ovf = 1'b1;
		cyc(1);
		ovf = 1'b0;
		alert_is(1'b1);
		wr(fagc_pkg::ADDR_ALERT_CTRL, 8'h40);
		alert_is(1'b0);
		rd(fagc_pkg::ADDR_ALERT_CTRL, 8'h40);
		wr(fagc_pkg::ADDR_ALERT_CTRL, 8'h00);
		alert_is(1'b1);
		wr(fagc_pkg::ADDR_FAULT_EN, 8'h40);
		wr(fagc_pkg::ADDR_BAD_WAIT, 8'h02);
		bad = 1'b1;
		cyc(2 * MS - 1);
		rd(fagc_pkg::ADDR_FAULT_LOG, 8'h00);
		rd(fagc_pkg::ADDR_FAULT_LOG, 8'h40);
		alert_is(1'b0);
		clr();
		bad = 1'b0;
		wr(fagc_pkg::ADDR_FAULT_LOG, 8'h00);
		wr(fagc_pkg::ADDR_BAD_WAIT, 8'h00);
		bad = 1'b1;
		cyc(20);
		rd(fagc_pkg::ADDR_FAULT_LOG, 8'h00);
		bad = 1'b0;
		fev.overvoltage = 1'b1;
		cyc(1);
		fev = '0;
		on_pin = 1'b1;
		cyc(2);
		rd(fagc_pkg::ADDR_FAULT_LOG, 8'h11);
		mask = 1'b0;
		on_pin = 1'b0;
		cyc(2);
		rd(fagc_pkg::ADDR_FAULT_LOG, 8'h10);
		for (int i = 0; i < 9; i++) begin
			pg = gp[i][1];
			stress = gp[i][0];
			ext = 3'($urandom);
			wr(fagc_pkg::ADDR_PIN_CFG, gc[i]);
			cyc(2);
			chk_pin("pin enable", ge[i], pin_oe_n);
			chk_pin("pin data", 3'h0, pin_out);
			chk_pin("pin level", pin_in, pin_lvl);
		end
		cyc(4);
		stop_test();
	end
endmodule
